// ===== core/fpr_partition_modes.sv
// Command decoder and per-partition read-mode selection behind an AXI4-Lite window
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module fpr_partition_modes
  import fpr_pkg::*;
#(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5a01  // Arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [WADDR_BITS-1:0] array_raddr,
  input wire logic [15:0] array_rdata,
  input wire logic [1:0] block_lock_state,
  input wire logic [NPART-1:0] part_busy,
  input wire logic wsm_suspended,
  input wire logic [3:0] wsm_flags,
  input wire logic [15:0] prot_lock_data,
  input wire logic [16*PROT_WORDS-1:0] prot_reg_data,
  output fpr_op_s wsm_op,
  output logic wsm_op_valid,
  output logic [15:0] config_code
);
  logic rst_s1_reg;
  logic rst_n_s;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_s <= rst_s1_reg;
    end
  end

  // Write channel capture; address and data may arrive in either order
  logic aw_have_reg, w_have_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic wr_go, wr_ok;
  logic [WADDR_BITS-1:0] wr_waddr;
  logic [PART_BITS-1:0] wr_part;
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_ok = (aw_addr_reg[AXI_AW-1:WADDR_BITS+BYTE_LSB] == '0);
  assign wr_waddr = aw_addr_reg[WADDR_BITS+BYTE_LSB-1:BYTE_LSB];
  assign wr_part = wr_waddr[WADDR_BITS-1:POFF_BITS];

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_have_reg) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[15:0];
        s_axi_wready <= 1'b0;
      end else if (!w_have_reg) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command decode
  logic pend_reg;
  logic [7:0] pend_code_reg;
  logic [PART_BITS-1:0] pend_part_reg;
  logic [7:0] wr_cmd;
  logic confirm_ok, mode_chg, pend_set, pend_clr, seq_err, clr_err, op_fire, cfg_wr;
  logic [7:0] op_code;
  fpr_mode_e mode_new;
  always_comb begin
    wr_cmd = w_data_reg[7:0];
    confirm_ok = 1'b0;
    mode_chg = 1'b0;
    mode_new = MODE_ARRAY;
    pend_set = 1'b0;
    pend_clr = 1'b0;
    seq_err = 1'b0;
    clr_err = 1'b0;
    op_fire = 1'b0;
    op_code = wr_cmd;
    cfg_wr = 1'b0;
    case (pend_code_reg)
      CMD_ERASE_SETUP, CMD_EFP_SETUP: confirm_ok = (wr_cmd == CMD_CONFIRM);
      CMD_LOCK_SETUP: confirm_ok = (wr_cmd == CMD_LOCK) || (wr_cmd == CMD_CONFIRM) ||
                                   (wr_cmd == CMD_LOCKDOWN) || (wr_cmd == CMD_SET_CFG);
      default: confirm_ok = 1'b1;
    endcase
    if (wr_go && wr_ok) begin
      if (pend_reg) begin
        pend_clr = 1'b1;
        if (confirm_ok) begin
          op_fire = 1'b1;
          op_code = pend_code_reg;
          if (pend_code_reg == CMD_LOCK_SETUP && wr_cmd == CMD_SET_CFG) begin
            cfg_wr = 1'b1;
            mode_chg = 1'b1;
            mode_new = MODE_ARRAY;
          end
        end else begin
          seq_err = 1'b1;
        end
      end else begin
        case (wr_cmd)
          CMD_READ_ARRAY: begin
            mode_chg = 1'b1;
            mode_new = MODE_ARRAY;
          end
          CMD_READ_ID: begin
            mode_chg = 1'b1;
            mode_new = MODE_IDENT;
          end
          CMD_READ_QUERY: begin
            mode_chg = 1'b1;
            mode_new = MODE_QUERY;
          end
          CMD_READ_STATUS: begin
            mode_chg = 1'b1;
            mode_new = MODE_STATUS;
          end
          CMD_CLEAR_STATUS: clr_err = 1'b1;
          CMD_SUSPEND, CMD_CONFIRM: op_fire = 1'b1;
          CMD_ERASE_SETUP, CMD_PROG_SETUP, CMD_PROG_SETUP_ALT, CMD_EFP_SETUP, CMD_LOCK_SETUP,
          CMD_PROT_SETUP: begin
            pend_set = 1'b1;
            mode_chg = 1'b1;
            mode_new = MODE_STATUS;
          end
          default: mode_chg = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pend_reg <= 1'b0;
      pend_code_reg <= '0;
      pend_part_reg <= '0;
    end else if (pend_set) begin
      pend_reg <= 1'b1;
      pend_code_reg <= wr_cmd;
      pend_part_reg <= wr_part;
    end else if (pend_clr) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wsm_op <= '0;
      wsm_op_valid <= 1'b0;
      config_code <= CFG_RESET;
    end else begin
      wsm_op_valid <= op_fire;
      if (op_fire) begin
        wsm_op <= '{code: op_code, addr: wr_waddr, data: w_data_reg};
      end
      if (cfg_wr) begin
        config_code <= wr_waddr[15:0];
      end
    end
  end

  // Per-partition read mode and sequence-error flags; set wins over clear
  fpr_mode_e mode_reg [NPART];
  logic [NPART-1:0] err_reg;
  for (genvar p = 0; p < NPART; p++) begin : g_part
    always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
        mode_reg[p] <= MODE_ARRAY;
        err_reg[p] <= 1'b0;
      end else begin
        if (mode_chg && wr_part == PART_BITS'(p)) begin
          mode_reg[p] <= mode_new;
        end
        if (seq_err && pend_part_reg == PART_BITS'(p)) begin
          err_reg[p] <= 1'b1;
        end else if (clr_err) begin
          err_reg[p] <= 1'b0;
        end
      end
    end
    property p_keep_other;
      @(posedge clk) disable iff (!rst_n_s) (wr_go && wr_part != PART_BITS'(p)) |=> $stable(mode_reg[p]);
    endproperty
    a_keep_other: assert property (p_keep_other) else $error("Command disturbed another partition");
    property p_reset_array;
      @(posedge clk) $rose(rst_n_s) |-> (mode_reg[p] == MODE_ARRAY && !err_reg[p]);
    endproperty
    a_reset_array: assert property (p_reset_array) else $error("Partition not in array mode after reset");
  end

  // Read path; suspended operations count as idle for array reads
  fpr_rd_e rd_state_reg;
  logic [WADDR_BITS-1:0] rd_waddr_reg;
  logic rd_ok_reg;
  fpr_mode_e rd_mode_reg;
  logic [NPART-1:0] busy_eff;
  logic [PART_BITS-1:0] rd_part;
  logic [POFF_BITS-1:0] rd_poff;
  logic [7:0] sr_byte;
  logic [15:0] rd_word;
  logic [7:0] prot_idx;
  assign busy_eff = part_busy & ~{NPART{wsm_suspended}};
  assign rd_part = rd_waddr_reg[WADDR_BITS-1:POFF_BITS];
  assign rd_poff = rd_waddr_reg[POFF_BITS-1:0];

  function automatic logic [7:0] query_byte(input logic [POFF_BITS-1:0] off);
    case (off)
      QRY_Q_OFF: query_byte = QRY_Q;
      QRY_R_OFF: query_byte = QRY_R;
      QRY_Y_OFF: query_byte = QRY_Y;
      default: query_byte = 8'h00;
    endcase
  endfunction : query_byte

  always_comb begin
    prot_idx = 8'(rd_poff[7:0] - ID_PREG_FIRST[7:0]);
    sr_byte = {1'b0, wsm_flags[3], err_reg[rd_part], err_reg[rd_part], wsm_flags[2:0], 1'b0};
    sr_byte[SR_READY] = ~|busy_eff || err_reg[rd_part];
    sr_byte[0] = |busy_eff && !busy_eff[rd_part];
    case (mode_reg[rd_part])
      MODE_ARRAY: rd_word = busy_eff[rd_part] ? INVALID_DATA : array_rdata;
      MODE_STATUS: rd_word = {8'h00, sr_byte};
      MODE_QUERY: rd_word = {8'h00, query_byte(rd_poff)};
      MODE_IDENT: begin
        if (rd_poff == ID_MFR_OFF) begin
          rd_word = MFR_CODE;
        end else if (rd_poff == ID_DEV_OFF) begin
          rd_word = DEV_CODE;
        end else if (rd_waddr_reg[BLK_OFF_BITS-1:0] == ID_LOCK_OFF) begin
          rd_word = {14'h0000, block_lock_state};
        end else if (rd_poff == ID_CFG_OFF) begin
          rd_word = config_code;
        end else if (rd_poff == ID_PLOCK_OFF) begin
          rd_word = prot_lock_data;
        end else if (rd_poff >= ID_PREG_FIRST && rd_poff <= ID_PREG_LAST) begin
          rd_word = prot_reg_data[16*prot_idx[2:0] +: 16];
        end else begin
          rd_word = 16'h0000;
        end
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // One beat per address; status mode never bursts since every read is single
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rd_state_reg <= RD_IDLE;
      rd_waddr_reg <= '0;
      rd_ok_reg <= 1'b0;
      rd_mode_reg <= MODE_ARRAY;
      array_raddr <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            rd_waddr_reg <= s_axi_araddr[WADDR_BITS+BYTE_LSB-1:BYTE_LSB];
            array_raddr <= s_axi_araddr[WADDR_BITS+BYTE_LSB-1:BYTE_LSB];
            rd_ok_reg <= (s_axi_araddr[AXI_AW-1:WADDR_BITS+BYTE_LSB] == '0);
            rd_state_reg <= RD_FETCH;
          end
        end
        RD_FETCH: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rdata <= rd_ok_reg ? {16'h0000, rd_word} : '0;
          s_axi_rresp <= rd_ok_reg ? RESP_OKAY : RESP_SLVERR;
          rd_mode_reg <= mode_reg[rd_part];
          rd_state_reg <= RD_RESP;
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  property p_setup_status;
    @(posedge clk) disable iff (!rst_n_s) pend_set |=> (mode_reg[$past(wr_part)] == MODE_STATUS) && pend_reg;
  endproperty
  a_setup_status: assert property (p_setup_status) else $error("Setup write did not select status mode");
  property p_seq_err;
    @(posedge clk) disable iff (!rst_n_s)
      (wr_go && wr_ok && pend_reg && !confirm_ok) |=> err_reg[$past(pend_part_reg)] && !pend_reg;
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("Foreign write not flagged");
  property p_read_array;
    @(posedge clk) disable iff (!rst_n_s)
      (wr_go && wr_ok && !pend_reg && wr_cmd == CMD_READ_ARRAY) |=> mode_reg[$past(wr_part)] == MODE_ARRAY;
  endproperty
  a_read_array: assert property (p_read_array) else $error("Read-array command ignored");
  property p_read_id;
    @(posedge clk) disable iff (!rst_n_s)
      (wr_go && wr_ok && !pend_reg && wr_cmd == CMD_READ_ID) |=> mode_reg[$past(wr_part)] == MODE_IDENT;
  endproperty
  a_read_id: assert property (p_read_id) else $error("Identifier command ignored");
  property p_query_busy;
    @(posedge clk) disable iff (!rst_n_s)
      (wr_go && wr_ok && !pend_reg && wr_cmd == CMD_READ_QUERY && busy_eff[wr_part]) |=>
      mode_reg[$past(wr_part)] == MODE_QUERY;
  endproperty
  a_query_busy: assert property (p_query_busy) else $error("Query command did not hold");
  property p_status_upper;
    @(posedge clk) disable iff (!rst_n_s)
      $rose(s_axi_rvalid) && (rd_mode_reg == MODE_STATUS || rd_mode_reg == MODE_QUERY) |-> s_axi_rdata[31:8] == '0;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("Upper status or query byte not zero");
  property p_err_ready;
    @(posedge clk) disable iff (!rst_n_s)
      $rose(s_axi_rvalid) && rd_mode_reg == MODE_STATUS && err_reg[rd_part] && rd_ok_reg |->
      s_axi_rdata[SR_READY] && s_axi_rdata[SR_ERASE_ERR] && s_axi_rdata[SR_PROG_ERR];
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("Sequence error bits incomplete");
  property p_id_mfr;
    @(posedge clk) disable iff (!rst_n_s)
      (rd_state_reg == RD_FETCH && rd_ok_reg && mode_reg[rd_part] == MODE_IDENT && rd_poff == ID_MFR_OFF) |=>
      s_axi_rvalid ##0 s_axi_rdata[15:0] == MFR_CODE;
  endproperty
  a_id_mfr: assert property (p_id_mfr) else $error("Manufacturer code wrong");
endmodule : fpr_partition_modes
`default_nettype wire

// ===== core/fpr_pkg.sv
// Constants, types and carriers for the partition read-mode command interpreter
`default_nettype none
package fpr_pkg;
  localparam int NPART = 8;
  localparam int PART_BITS = 3;
  localparam int WADDR_BITS = 21;
  localparam int POFF_BITS = 18;
  localparam int BLK_OFF_BITS = 15;
  localparam int BYTE_LSB = 2;
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  localparam int PROT_WORDS = 8;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_EFP_SETUP = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_PROT_SETUP = 8'hc0;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2f;
  localparam logic [7:0] CMD_SET_CFG = 8'h03;

  localparam logic [17:0] ID_MFR_OFF = 18'h00000;
  localparam logic [17:0] ID_DEV_OFF = 18'h00001;
  localparam logic [14:0] ID_LOCK_OFF = 15'h0002;
  localparam logic [17:0] ID_CFG_OFF = 18'h00005;
  localparam logic [17:0] ID_PLOCK_OFF = 18'h00080;
  localparam logic [17:0] ID_PREG_FIRST = 18'h00081;
  localparam logic [17:0] ID_PREG_LAST = 18'h00088;
  localparam logic [17:0] PROT_LOCK_WADDR = 18'h00080;

  localparam logic [17:0] QRY_Q_OFF = 18'h00010;
  localparam logic [17:0] QRY_R_OFF = 18'h00011;
  localparam logic [17:0] QRY_Y_OFF = 18'h00012;
  localparam logic [7:0] QRY_Q = 8'h51;
  localparam logic [7:0] QRY_R = 8'h52;
  localparam logic [7:0] QRY_Y = 8'h59;

  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam logic [15:0] INVALID_DATA = 16'hffff;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_IDENT, MODE_QUERY} fpr_mode_e;
  typedef enum logic [1:0] {RD_IDLE, RD_FETCH, RD_RESP} fpr_rd_e;

  typedef struct packed {
    logic [7:0] code;
    logic [WADDR_BITS-1:0] addr;
    logic [15:0] data;
  } fpr_op_s;
endpackage : fpr_pkg
`default_nettype wire

// ===== test/fpr_array_model.sv
// Flash array and block-lock model behind the read port
`default_nettype none
module fpr_array_model
  import fpr_pkg::*;
(
  input wire logic [WADDR_BITS-1:0] raddr,
  output logic [15:0] rdata,
  output logic [1:0] lock
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pattern follows the address so a misrouted read shows up
  assign rdata = raddr[15:0] ^ 16'h5a5a;
  // Lock bits from the low block number bits
  assign lock = raddr[16:15];
endmodule : fpr_array_model
`default_nettype wire

// ===== test/fpr_partition_modes_test.sv
// Self-checking bench for the partition read-mode interpreter
`default_nettype none
module fpr_partition_modes_test
  import fpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid, susp, op_valid;
  logic bready, rready;
  logic [15:0] plock;
  logic [127:0] preg;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp, lock;
  logic [WADDR_BITS-1:0] raddr;
  logic [15:0] adata, cfg;
  logic [NPART-1:0] busy;
  logic [3:0] flags;
  fpr_op_s op, last_op;
  int n_mismatch, samples_checked, op_cnt;

  // Identity values are arbitrary
  fpr_partition_modes #(.MFR_CODE(16'h0c3e), .DEV_CODE(16'h7b12)) i_dut (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .array_raddr(raddr), .array_rdata(adata), .block_lock_state(lock),
    .part_busy(busy), .wsm_suspended(susp), .wsm_flags(flags),
    .prot_lock_data(plock), .prot_reg_data(preg),
    .wsm_op(op), .wsm_op_valid(op_valid), .config_code(cfg)
  );
  fpr_array_model i_arr (.raddr(raddr), .rdata(adata), .lock(lock));

  always #25 clk = ~clk;
  // Op pulse lasts one cycle, so it is latched here
  always @(posedge clk) begin
    if (op_valid === 1'b1) begin
      op_cnt <= op_cnt + 1;
      last_op <= op;
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t ns: no answer", $time);
      stop_test();
    end
  endtask : tmo

  function automatic logic [31:0] ba(input logic [2:0] p, input logic [17:0] o);
    return {9'h0, p, o, 2'b00};
  endfunction : ba

  function automatic logic [15:0] ex(input logic [17:0] o);
    return o[15:0] ^ 16'h5a5a;
  endfunction : ex

  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    tmo(bvalid);
    chk(bresp, er);
    // Idle edge so the next call never reassigns bready in this step
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rc(input logic [31:0] a, input logic [15:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    tmo(rvalid);
    chk(rdata, {16'h0, e});
    chk(rresp, er);
    rready <= 1'b0;
    @(posedge clk);
  endtask : rc

  task automatic t_reset();
    rc(ba(3'd0, 18'h00123), ex(18'h00123), RESP_OKAY);
    rc(ba(3'd7, 18'h3fffe), ex(18'h3fffe), RESP_OKAY);
  endtask : t_reset

  task automatic t_config();
    wr(ba(3'd6, 18'h01234), 16'h0060, RESP_OKAY);
    wr(ba(3'd6, 18'h01234), 16'h0003, RESP_OKAY);
    chk(cfg, 16'h1234);
    rc(ba(3'd6, 18'h00010), ex(18'h00010), RESP_OKAY);
  endtask : t_config

  task automatic t_ident();
    wr(ba(3'd1, 18'h0), 16'h0090, RESP_OKAY);
    rc(ba(3'd1, 18'h00000), 16'h0c3e, RESP_OKAY);
    rc(ba(3'd1, 18'h00001), 16'h7b12, RESP_OKAY);
    rc(ba(3'd1, 18'h18002), 16'h0003, RESP_OKAY);
    rc(ba(3'd1, 18'h08002), 16'h0001, RESP_OKAY);
    rc(ba(3'd1, 18'h00005), 16'h1234, RESP_OKAY);
    rc(ba(3'd1, 18'h00080), 16'h00fe, RESP_OKAY);
    rc(ba(3'd1, 18'h00081), 16'h1111, RESP_OKAY);
    rc(ba(3'd1, 18'h00088), 16'h8888, RESP_OKAY);
    rc(ba(3'd0, 18'h00005), ex(18'h00005), RESP_OKAY);
  endtask : t_ident

  task automatic t_query();
    busy <= 8'h04;
    wr(ba(3'd2, 18'h00040), 16'h0098, RESP_OKAY);
    rc(ba(3'd2, 18'h00010), 16'h0051, RESP_OKAY);
    rc(ba(3'd2, 18'h00011), 16'h0052, RESP_OKAY);
    rc(ba(3'd2, 18'h00012), 16'h0059, RESP_OKAY);
    busy <= 8'h00;
  endtask : t_query

  task automatic t_busy();
    busy <= 8'h20;
    wr(ba(3'd5, 18'h0), 16'h00ff, RESP_OKAY);
    rc(ba(3'd5, 18'h00040), INVALID_DATA, RESP_OKAY);
    wr(ba(3'd5, 18'h0), 16'h0090, RESP_OKAY);
    rc(ba(3'd5, 18'h0), 16'h0c3e, RESP_OKAY);
    susp <= 1'b1;
    wr(ba(3'd5, 18'h0), 16'h00ff, RESP_OKAY);
    rc(ba(3'd5, 18'h00040), ex(18'h00040), RESP_OKAY);
    busy <= 8'h00;
    susp <= 1'b0;
    rc(ba(3'd5, 18'h00041), ex(18'h00041), RESP_OKAY);
  endtask : t_busy

  task automatic t_seq();
    // Flags land in bits 6 and 2 of the status
    flags <= 4'ha;
    wr(ba(3'd3, 18'h00200), 16'h0020, RESP_OKAY);
    rc(ba(3'd3, 18'h00200), 16'h00c4, RESP_OKAY);
    rc(ba(3'd0, 18'h00300), ex(18'h00300), RESP_OKAY);
    wr(ba(3'd4, 18'h0), 16'h00ff, RESP_OKAY);
    rc(ba(3'd3, 18'h00200), 16'h00f4, RESP_OKAY);
    wr(ba(3'd3, 18'h00200), 16'h00ff, RESP_OKAY);
    rc(ba(3'd3, 18'h00200), ex(18'h00200), RESP_OKAY);
    wr(ba(3'd3, 18'h0), 16'h0050, RESP_OKAY);
    wr(ba(3'd3, 18'h0), 16'h0070, RESP_OKAY);
    rc(ba(3'd3, 18'h0), 16'h00c4, RESP_OKAY);
    flags <= 4'h0;
  endtask : t_seq

  task automatic t_prot();
    int c;
    fpr_op_s e;
    c = op_cnt;
    e = '{code: 8'hc0, addr: 21'h00080, data: 16'hfffd};
    wr(ba(3'd0, PROT_LOCK_WADDR), 16'h00c0, RESP_OKAY);
    wr(ba(3'd0, PROT_LOCK_WADDR), 16'hfffd, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(op_cnt - c, 1);
    chk(last_op, e);
    e = '{code: 8'hb0, addr: 21'h080100, data: 16'h00b0};
    wr(ba(3'd2, 18'h00100), 16'h00b0, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(op_cnt - c, 2);
    chk(last_op, e);
  endtask : t_prot

  task automatic t_unmap();
    wr(32'h8000_0000, 16'h0090, RESP_SLVERR);
    rc(32'h8000_0000, 16'h0000, RESP_SLVERR);
    // Partition 0 still in status mode from the protection setup
    rc(ba(3'd0, 18'h00007), 16'h0080, RESP_OKAY);
  endtask : t_unmap

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    busy = 8'h00;
    susp = 1'b0;
    flags = 4'h0;
    bready = 1'b0;
    rready = 1'b0;
    plock = 16'h00fe;
    preg = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_config();
    t_ident();
    t_query();
    t_busy();
    t_seq();
    t_prot();
    t_unmap();
    stop_test();
  end
endmodule : fpr_partition_modes_test
`default_nettype wire
